/* File: rtl/ipb_builder.v */
// image packet body builder: channel word, per-segment headers, packed image words
// assumes one source on sys_clk_in; packet header and trailer are added downstream
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "ipb_defines.vh"

// Operation
// - bits 31-30 give segment position
// - bits 29-28 give image count content
// - bit 27 flags per-segment header present
// - bits 26-23 give still format code
// - bits 22-0 reserved in still word
// - header precedes each image after channel word
// - header is 12 bytes: low, high, length
// - relative time 48 bits, upper zeroed
// - absolute time when flag bit 6 set
// - length word holds following byte count
// - bytes paired low first, odd filled
// - packet holds segments or whole images
// - each dynamic source has own channel
// - one dynamic format per channel
// - setup record before changed dynamic settings
// - dynamic bits 26-21 hold pixel format
// - dynamic header length is image bytes
module ipb_builder (
  input  wire        sys_clk_in,
  input  wire        srst_in,
  input  wire [3:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  input  wire [47:0] rel_time_in,
  input  wire        pkt_start_in,
  input  wire [1:0]  part_in,
  input  wire [1:0]  sum_in,
  input  wire        seg_start_in,
  input  wire [31:0] seg_len_in,
  input  wire        byte_valid_in,
  input  wire [7:0]  byte_in,
  input  wire        byte_last_in,
  output reg         byte_ready_out,
  output reg         word_valid_out,
  output reg  [15:0] word_out,
  output reg         word_last_out,
  output reg         setup_req_out
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CHAN = 2'd1;
  localparam ST_HDR  = 2'd2;
  localparam ST_DATA = 2'd3;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [31:0] ctrl;
  reg  [15:0] chan_id;
  reg  [5:0]  dyn_fmt;
  reg  [63:0] abs_time;
  reg  [31:0] pkt_count;
  reg         setup_pend;
  reg         cfg_lock;
  reg  [2:0]  idx;
  reg  [1:0]  p_part;
  reg  [1:0]  p_sum;
  reg  [63:0] stamp;
  reg  [31:0] seg_len;
  reg  [15:0] hdr_word;
  reg  [31:0] next_ctrl;
  // bytes taken so far in the current segment, held against its length
  reg  [31:0] byte_cnt;
  reg         len_err;
  wire [31:0] chan_word;
  wire        pk_valid;
  wire [15:0] pk_word;
  wire        pk_last;
  wire        mode    = ctrl[0];
  wire        hdr_en  = ctrl[1];
  wire        abs_en  = ctrl[6];
  wire [3:0]  s_fmt   = ctrl[11:8];
  wire        pk_feed = byte_valid_in & byte_ready_out;
  wire [31:0] next_byte_cnt = byte_cnt + 32'h0000_0001;
  wire        status_wr = reg_wr_in & (reg_addr_in == `IPB_REG_STATUS);
  wire        cfg_wr  = reg_wr_in & ((reg_addr_in == `IPB_REG_CHAN) |
                        (reg_addr_in == `IPB_REG_DFMT) | (reg_addr_in == `IPB_REG_CTRL));

  ipb_chan_word u_chan (
    .mode_in      (mode),
    .part_in      (p_part),
    .sum_in       (p_sum),
    .hdr_en_in    (hdr_en),
    .still_fmt_in (s_fmt),
    .dyn_fmt_in   (dyn_fmt),
    .word_out     (chan_word)
  );

  ipb_byte_pack u_pack (
    .sys_clk_in     (sys_clk_in),
    .srst_in        (srst_in),
    .byte_valid_in  (pk_feed),
    .byte_in        (byte_in),
    .byte_last_in   (byte_last_in),
    .word_valid_out (pk_valid),
    .word_out       (pk_word),
    .word_last_out  (pk_last)
  );

  // header as six 16-bit words, low half first; word 0 leaves straight from the time source
  always @* begin
    case (idx)
      3'd1:    hdr_word = stamp[31:16];
      3'd2:    hdr_word = stamp[47:32];
      3'd3:    hdr_word = stamp[63:48];
      3'd4:    hdr_word = seg_len[15:0];
      3'd5:    hdr_word = seg_len[31:16];
      default: hdr_word = stamp[15:0];
    endcase
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (pkt_start_in && !setup_pend) begin
          next_state = ST_CHAN;
        end
      end
      ST_CHAN: begin
        if (idx == 3'd1) begin
          next_state = ST_HDR;
        end
      end
      ST_HDR: begin
        // a packet ends between segments, never inside a header
        if (idx == 3'd0 && pkt_start_in && !seg_start_in) begin
          next_state = ST_IDLE;
        end
        if (seg_start_in) begin
          next_state = hdr_en ? ST_HDR : ST_DATA;
        end
        if (idx != 3'd0) begin
          next_state = (idx == `IPB_HDR_WORDS - 3'd1) ? ST_DATA : ST_HDR;
        end
      end
      ST_DATA: begin
        if (pk_valid && pk_last) begin
          next_state = ST_HDR;
        end
        // ending inside a segment cuts it; a pending low byte stays in the packer and pairs with the next byte fed
        if (pkt_start_in) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      state          <= ST_IDLE;
      idx            <= 3'd0;
      p_part         <= 2'b00;
      p_sum          <= 2'b00;
      stamp          <= 64'h0000_0000_0000_0000;
      seg_len        <= 32'h0000_0000;
      byte_ready_out <= 1'b0;
      word_valid_out <= 1'b0;
      word_out       <= 16'h0000;
      word_last_out  <= 1'b0;
      pkt_count      <= 32'h0000_0000;
    end else begin
      state          <= next_state;
      word_valid_out <= 1'b0;
      word_last_out  <= 1'b0;
      byte_ready_out <= (next_state == ST_DATA) && !(pk_feed && byte_last_in);
      case (state)
        ST_IDLE: begin
          idx <= 3'd0;
          if (pkt_start_in && !setup_pend) begin
            p_part <= part_in;
            p_sum  <= sum_in;
          end
        end
        ST_CHAN: begin
          word_valid_out <= 1'b1;
          word_out       <= idx[0] ? chan_word[31:16] : chan_word[15:0];
          idx            <= idx[0] ? 3'd0 : 3'd1;
          if (idx[0]) begin
            pkt_count <= pkt_count + 32'h0000_0001;
          end
        end
        ST_HDR: begin
          if (idx == 3'd0 && seg_start_in) begin
            seg_len <= seg_len_in;
            if (abs_en) begin
              stamp <= abs_time;
            end else begin
              stamp <= {16'h0000, rel_time_in};
            end
            idx <= hdr_en ? 3'd1 : 3'd0;
            if (hdr_en) begin
              word_valid_out <= 1'b1;
              word_out       <= abs_en ? abs_time[15:0] : rel_time_in[15:0];
            end
          end else if (idx != 3'd0) begin
            word_valid_out <= 1'b1;
            word_out       <= hdr_word;
            idx            <= (idx == `IPB_HDR_WORDS - 3'd1) ? 3'd0 : idx + 3'd1;
          end
        end
        ST_DATA: begin
          if (pk_valid) begin
            word_valid_out <= 1'b1;
            word_out       <= pk_word;
            word_last_out  <= pk_last;
          end
        end
        default: idx <= 3'd0;
      endcase
    end
  end

  // still format codes above the last defined one keep the old setting;
  // bit 3 shows its reset value only until the first write
  always @* begin
    next_ctrl      = 32'h0000_0000;
    next_ctrl[1:0] = reg_wdata_in[1:0];
    next_ctrl[6]   = reg_wdata_in[6];
    if (reg_wdata_in[11:8] > `IPB_SFMT_MAX) begin
      next_ctrl[11:8] = s_fmt;
    end else begin
      next_ctrl[11:8] = reg_wdata_in[11:8];
    end
  end

  // a last marker that disagrees with the announced length leaves the
  // header's length word wrong; the mismatch is kept for software to see
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      byte_cnt <= 32'h0000_0000;
      len_err  <= 1'b0;
    end else begin
      if (state == ST_HDR && idx == 3'd0 && seg_start_in) begin
        byte_cnt <= 32'h0000_0000;
      end else if (pk_feed) begin
        byte_cnt <= next_byte_cnt;
      end
      // a new mismatch wins over a clear in the same cycle
      if (pk_feed && byte_last_in && next_byte_cnt != seg_len) begin
        len_err <= 1'b1;
      end else if (status_wr && reg_wdata_in[1]) begin
        len_err <= 1'b0;
      end
    end
  end

  // software side; dynamic format and channel change only between packets
  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl          <= `IPB_CTRL_RESET;
      chan_id       <= `IPB_CHAN_RESET;
      dyn_fmt       <= 6'h00;
      abs_time      <= 64'h0000_0000_0000_0000;
      setup_pend    <= 1'b0;
      setup_req_out <= 1'b0;
      cfg_lock      <= 1'b0;
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      cfg_lock <= (state != ST_IDLE);
      if (reg_wr_in && !cfg_lock) begin
        case (reg_addr_in)
          `IPB_REG_CTRL: begin
            ctrl <= next_ctrl;
          end
          `IPB_REG_CHAN: chan_id <= reg_wdata_in[15:0];
          `IPB_REG_DFMT: dyn_fmt <= reg_wdata_in[5:0];
          `IPB_REG_ABS_LO: abs_time[31:0] <= reg_wdata_in;
          `IPB_REG_ABS_HI: abs_time[63:32] <= reg_wdata_in;
          default: ;
        endcase
      end
      // a new config write wins over the acknowledge in the same cycle
      if (cfg_wr && !cfg_lock && mode) begin
        setup_pend <= 1'b1;
      end else if (status_wr && reg_wdata_in[0]) begin
        setup_pend <= 1'b0;
      end
      setup_req_out <= setup_pend;
      reg_rdata_out <= 32'h0000_0000;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `IPB_REG_CTRL:   reg_rdata_out <= ctrl;
          `IPB_REG_CHAN:   reg_rdata_out <= {16'h0000, chan_id};
          `IPB_REG_DFMT:   reg_rdata_out <= {26'h000_0000, dyn_fmt};
          `IPB_REG_STATUS: reg_rdata_out <= {27'h000_0000, cfg_lock, state, len_err, setup_pend};
          `IPB_REG_ABS_LO: reg_rdata_out <= abs_time[31:0];
          `IPB_REG_ABS_HI: reg_rdata_out <= abs_time[63:32];
          `IPB_REG_COUNT:  reg_rdata_out <= pkt_count;
          default:         reg_rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

/* File: rtl/ipb_byte_pack.v */
// packs image bytes two per 16-bit word, earlier byte low, filler on odd tail
// assumes bytes arrive on the same clock with a last marker on the final byte
`timescale 1ns/1ns
`include "ipb_defines.vh"

module ipb_byte_pack #(
  parameter [7:0] FILL = 8'h00
) (
  input  wire        sys_clk_in,
  input  wire        srst_in,
  input  wire        byte_valid_in,
  input  wire [7:0]  byte_in,
  input  wire        byte_last_in,
  output reg         word_valid_out,
  output reg  [15:0] word_out,
  output reg         word_last_out
);
  reg       half;
  reg [7:0] low_byte;

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      half           <= 1'b0;
      low_byte       <= 8'h00;
      word_valid_out <= 1'b0;
      word_out       <= 16'h0000;
      word_last_out  <= 1'b0;
    end else begin
      word_valid_out <= 1'b0;
      word_last_out  <= 1'b0;
      if (byte_valid_in) begin
        if (half) begin
          word_out       <= {byte_in, low_byte};
          word_valid_out <= 1'b1;
          word_last_out  <= byte_last_in;
          half           <= 1'b0;
        end else if (byte_last_in) begin
          word_out       <= {FILL, byte_in};
          word_valid_out <= 1'b1;
          word_last_out  <= 1'b1;
        end else begin
          low_byte <= byte_in;
          half     <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: rtl/ipb_chan_word.v */
// builds the 32-bit channel word for still or dynamic imagery packets
// assumes field inputs are held stable by the caller while the word is sampled
`timescale 1ns/1ns
`include "ipb_defines.vh"

module ipb_chan_word (
  input  wire        mode_in,
  input  wire [1:0]  part_in,
  input  wire [1:0]  sum_in,
  input  wire        hdr_en_in,
  input  wire [3:0]  still_fmt_in,
  input  wire [5:0]  dyn_fmt_in,
  output reg  [31:0] word_out
);
  always @* begin
    word_out = 32'h0000_0000;
    word_out[`IPB_PART_HI:`IPB_PART_LO] = part_in;
    word_out[`IPB_SUM_HI:`IPB_SUM_LO]   = sum_in;
    word_out[`IPB_HDR_BIT]              = hdr_en_in;
    if (mode_in == `IPB_FMT_DYNAMIC) begin
      word_out[`IPB_DFMT_HI:`IPB_DFMT_LO] = dyn_fmt_in;
    end else begin
      word_out[`IPB_SFMT_HI:`IPB_SFMT_LO] = still_fmt_in;
    end
    // all other bits stay zero
  end
endmodule

/* File: rtl/ipb_defines.vh */
// constants for the image packet builder: channel word fields, header layout, register map
// assumes inclusion by every design file of the block, no other dependency
`ifndef IPB_DEFINES_VH
`define IPB_DEFINES_VH

`define IPB_PART_HI        31
`define IPB_PART_LO        30
`define IPB_SUM_HI         29
`define IPB_SUM_LO         28
`define IPB_HDR_BIT        27
`define IPB_SFMT_HI        26
`define IPB_SFMT_LO        23
`define IPB_DFMT_HI        26
`define IPB_DFMT_LO        21
`define IPB_SFMT_MAX       4'h3
`define IPB_HDR_WORDS      3'h6
`define IPB_REL_TIME_BITS  48

`define IPB_FMT_STILL      1'b0
`define IPB_FMT_DYNAMIC    1'b1

`define IPB_REG_CTRL       4'h0
`define IPB_REG_CHAN       4'h1
`define IPB_REG_DFMT       4'h2
`define IPB_REG_STATUS     4'h3
`define IPB_REG_ABS_LO     4'h4
`define IPB_REG_ABS_HI     4'h5
`define IPB_REG_COUNT      4'h6

`define IPB_CTRL_RESET     32'h0000_0008
`define IPB_CHAN_RESET     16'h0001

`endif

/* File: testbench/ipb_builder_bench.sv */
// self-checking bench for the image packet builder
// assumes the design files and the checker are compiled before this file
`timescale 1ns/1ns
`include "ipb_defines.vh"
module ipb_builder_bench;
  logic        sys_clk_in = 0, srst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic        pkt_start_in = 0, seg_start_in = 0, go = 0, stall = 0, done;
  logic [3:0]  reg_addr_in = 0;
  logic [31:0] reg_wdata_in = 0, reg_rdata_out, seg_len_in = 0;
  logic [47:0] rel_time_in = 0;
  logic [1:0]  part_in = 0, sum_in = 0;
  logic        byte_valid_in, byte_last_in, byte_ready_out, word_valid_out, word_last_out;
  logic        setup_req_out;
  logic [7:0]  byte_in;
  logic [15:0] word_out;
  logic [16:0] got[$], exp[$];
  int          num_errors = 0, samples_checked = 0, cycles = 0;
  ipb_builder u_ipb_builder (.sys_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .rel_time_in, .pkt_start_in, .part_in, .sum_in, .seg_start_in,
    .seg_len_in, .byte_valid_in, .byte_in, .byte_last_in, .byte_ready_out, .word_valid_out,
    .word_out, .word_last_out, .setup_req_out);
  ipb_image_source u_ipb_image_source (.sys_clk_in, .srst_in, .go_in(go), .count_in(seg_len_in),
    .stall_in(stall), .byte_ready_in(byte_ready_out), .byte_valid_out(byte_valid_in),
    .byte_out(byte_in), .byte_last_out(byte_last_in), .done_out(done));
  always #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (word_valid_out === 1'b1) got.push_back({word_last_out, word_out});
    if (cycles == 20000) begin
      num_errors++;
      wrap_up;
    end
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] want);
    @(posedge sys_clk_in);
    reg_rd_in <= 1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 0;
    #1 check("rdata", reg_rdata_out, want);
  endtask
  task automatic start_pkt(logic [1:0] p, logic [1:0] s, logic [31:0] chan);
    @(posedge sys_clk_in);
    pkt_start_in <= 1;
    part_in <= p;
    sum_in <= s;
    @(posedge sys_clk_in);
    pkt_start_in <= 0;
    exp.push_back({1'b0, chan[15:0]});
    exp.push_back({1'b0, chan[31:16]});
    repeat (3) @(posedge sys_clk_in);
  endtask
  // queue header (if hdr) and packed words, then feed n bytes and wait for the source
  task automatic seg(int n, logic hdr, logic [63:0] t);
    logic [95:0] h;
    h = {32'(n), t};
    for (int k = 0; k < 6 && hdr; k++) exp.push_back({1'b0, h[16*k +: 16]});
    for (int i = 0; i < n; i += 2) exp.push_back({i + 2 >= n, 8'(i + 1 < n ? 'h41 + i : 0),
      8'('h40 + i)});
    @(posedge sys_clk_in);
    seg_start_in <= 1;
    seg_len_in <= n;
    go <= 1;
    @(posedge sys_clk_in);
    seg_start_in <= 0;
    go <= 0;
    #1;
    for (int k = 0; k < 300 && !done; k++) @(posedge sys_clk_in);
  endtask
  task automatic cmp_stream;
    for (int k = 0; k < 100 && got.size() < exp.size(); k++) @(posedge sys_clk_in);
    repeat (4) @(posedge sys_clk_in);
    check("count", got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) check("word", got[i], exp[i]);
    got.delete();
    exp.delete();
    start_pkt(0, 0, 0);
    exp.delete();
  endtask
  task automatic t_regs;
    rd(`IPB_REG_CTRL, 32'h0000_0008);
    rd(`IPB_REG_CHAN, 32'h0000_0001);
    rd(4'hf, 32'h0000_0000);
    for (int f = 0; f < 4; f++) begin
      wr(`IPB_REG_CTRL, 32'(f) << 8);
      rd(`IPB_REG_CTRL, 32'(f) << 8);
    end
  endtask
  task automatic t_still;
    wr(`IPB_REG_CTRL, 32'h0000_0302);
    rel_time_in <= 48'h1234_5678_9abc;
    start_pkt(2'b11, 2'b01, {2'b11, 2'b01, 1'b1, 4'h3, 23'h0});
    seg(5, 1, 64'h0000_1234_5678_9abc);
    stall <= 1;
    seg(2, 1, 64'h0000_1234_5678_9abc);
    stall <= 0;
    cmp_stream;
    wr(`IPB_REG_CTRL, 32'h0000_0000);
    wr(`IPB_REG_CTRL, 32'h0000_0500);
    rd(`IPB_REG_CTRL, 32'h0000_0000);
    start_pkt(2'b01, 2'b00, {2'b01, 2'b00, 1'b0, 4'h0, 23'h0});
    seg(4, 0, 0);
    cmp_stream;
    wr(`IPB_REG_ABS_LO, 32'h1357_9bdf);
    wr(`IPB_REG_ABS_HI, 32'h2468_ace0);
    wr(`IPB_REG_CTRL, 32'h0000_0242);
    start_pkt(2'b10, 2'b11, {2'b10, 2'b11, 1'b1, 4'h2, 23'h0});
    seg(1, 1, 64'h2468_ace0_1357_9bdf);
    cmp_stream;
  endtask
  task automatic t_dyn;
    wr(`IPB_REG_CTRL, 32'h0000_0003);
    wr(`IPB_REG_DFMT, 32'h0000_002a);
    wr(`IPB_REG_CHAN, 32'h0000_0002);
    rd(`IPB_REG_CHAN, 32'h0000_0002);
    check("setup", setup_req_out, 1);
    start_pkt(2'b00, 2'b10, 0);
    check("refused", got.size(), 0);
    exp.delete();
    wr(`IPB_REG_STATUS, 32'h0000_0001);
    @(posedge sys_clk_in);
    #1 check("setup", setup_req_out, 0);
    rel_time_in <= 48'h0000_0000_0777;
    start_pkt(2'b00, 2'b10, {2'b00, 2'b10, 1'b1, 6'h2a, 21'h0});
    seg(2, 1, 64'h0000_0000_0000_0777);
    cmp_stream;
    rd(`IPB_REG_COUNT, 32'h0000_0004);
    rd(`IPB_REG_STATUS, 32'h0000_0000);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_in);
    srst_in <= 0;
    t_regs;
    t_still;
    t_dyn;
    wrap_up;
  end
endmodule

/* File: testbench/ipb_checker_properties.sv */
// concurrent checks on the packet builder stream and register port
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`include "ipb_defines.vh"
module ipb_checker (
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        pkt_start_in,
  input wire logic        byte_ready_out,
  input wire logic        word_valid_out,
  input wire logic        word_last_out,
  input wire logic        setup_req_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);
  a_reset_quiet: assert property ($fell(srst_in) |-> !word_valid_out && !setup_req_out
    && !byte_ready_out) else $error("output active after reset");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_last_valid: assert property (word_last_out |-> word_valid_out)
    else $error("last marker without word");
  a_last_once: assert property (word_last_out |=> !word_last_out)
    else $error("last marker repeated");
  a_setup_cause: assert property ($rose(setup_req_out) |-> $past(reg_wr_in, 2)
    && $past(reg_addr_in, 2) <= `IPB_REG_DFMT)
    else $error("setup request without config write");
  a_setup_clear: assert property (reg_wr_in && reg_addr_in == `IPB_REG_STATUS
    && reg_wdata_in[0] |=> ##1 !setup_req_out) else $error("setup request not cleared");
  a_setup_holds: assert property (setup_req_out && !(reg_wr_in
    && reg_addr_in == `IPB_REG_STATUS) && !($past(reg_wr_in)
    && $past(reg_addr_in) == `IPB_REG_STATUS) |=> setup_req_out)
    else $error("setup request dropped");
  a_pend_silent: assert property (setup_req_out && pkt_start_in |-> ##2 !word_valid_out)
    else $error("packet started while setup pending");
endmodule
bind ipb_builder ipb_checker u_ipb_checker (.sys_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pkt_start_in, .byte_ready_out, .word_valid_out,
  .word_last_out, .setup_req_out);

/* File: testbench/ipb_image_source.sv */
// image byte source model: byte i of a segment carries 8'h40 + i
// assumes the builder's ready is registered; stall adds one idle cycle per byte
`timescale 1ns/1ns
module ipb_image_source (
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        go_in,
  input  wire logic [31:0] count_in,
  input  wire logic        stall_in,
  input  wire logic        byte_ready_in,
  output logic             byte_valid_out,
  output logic [7:0]       byte_out,
  output logic             byte_last_out,
  output logic             done_out
);
  logic [31:0] left;
  logic [7:0]  idx;
  assign done_out = left == 0 && !byte_valid_out;
  always @(posedge sys_clk_in) begin
    if (srst_in || go_in) begin
      left <= srst_in ? 32'h0000_0000 : count_in;
      idx <= 8'h00;
      byte_valid_out <= 1'b0;
      byte_last_out <= 1'b0;
    end else if (byte_valid_out && byte_ready_in) begin
      idx <= idx + 8'h01;
      left <= left - 32'h0000_0001;
      if (left == 1 || stall_in) begin
        byte_valid_out <= 1'b0;
        byte_last_out <= 1'b0;
        // released line shows the inverse, never the stale byte
        byte_out <= ~byte_out;
      end else begin
        byte_out <= 8'h41 + idx;
        byte_last_out <= left == 2;
      end
    end else if (!byte_valid_out && left != 0) begin
      byte_valid_out <= 1'b1;
      byte_out <= 8'h40 + idx;
      byte_last_out <= left == 1;
    end
  end
endmodule
